// [apr_pkg.sv]
// Constants for the audio port routing and status flag block.
// Assumes an 8-bit register port driven by the control-bus engine.
package apr_pkg;
	// Register port width
	localparam int APR_REG_W = 8;
	// Register offsets
	localparam logic [7:0] APR_OFS_SRC_SEL = 8'h1f;
	localparam logic [7:0] APR_OFS_IN_SEL = 8'h20;
	localparam logic [7:0] APR_OFS_OUT_SEL = 8'h21;
	localparam logic [7:0] APR_OFS_BUS_COND = 8'h22;
	localparam logic [7:0] APR_OFS_RSVD_23 = 8'h23;
	localparam logic [7:0] APR_OFS_REC_FLAGS = 8'h24;
	localparam logic [7:0] APR_OFS_PLAY_PWR = 8'h25;
	localparam logic [7:0] APR_OFS_PLAY_GAIN = 8'h26;
	// Reset value of every control register
	localparam logic [7:0] APR_RST_REG = 8'h00;
	// Writable reserved bits of the record flag register
	localparam logic [7:0] APR_REC_RW_MASK = 8'h1f;
	// Field positions, secondary pin source select
	localparam int APR_POS_SEC_BCLK_SRC = 5;
	localparam int APR_POS_SEC_WCLK_SRC = 2;
	localparam int APR_POS_SEC_DIN_SRC = 0;
	// Field positions, serial port input select
	localparam int APR_POS_REC_WCLK_SRC = 5;
	localparam int APR_POS_SIF_BCLK_SEL = 3;
	localparam int APR_POS_SIF_WCLK_SEL = 2;
	localparam int APR_POS_REC_WCLK_SEL = 1;
	localparam int APR_POS_SIF_DIN_SEL = 0;
	// Field positions, serial port output select
	localparam int APR_POS_PBCLK_OUT = 7;
	localparam int APR_POS_SBCLK_OUT = 6;
	localparam int APR_POS_PWCLK_OUT = 4;
	localparam int APR_POS_SWCLK_OUT = 2;
	localparam int APR_POS_PDOUT_SEL = 1;
	localparam int APR_POS_SDOUT_SEL = 0;
	// Field positions, bus condition and flags
	localparam int APR_POS_GCALL = 5;
	localparam int APR_POS_ADC_GAIN_OK = 7;
	localparam int APR_POS_ADC_PWR = 6;
	localparam int APR_POS_AGC_SAT = 5;
	localparam int APR_POS_DAC_PWR = 7;
	localparam int APR_POS_HP_PWR = 5;
	localparam int APR_POS_CLASSD_PWR = 4;
	localparam int APR_POS_DAC_GAIN_OK = 4;
	// Secondary clock source codes
	localparam logic [2:0] APR_SRC_GPIO = 3'h0;
	localparam logic [2:0] APR_SRC_DOUT = 3'h3;
	// Secondary data and record word clock source codes
	localparam logic [1:0] APR_DIN_GPIO = 2'h0;
	localparam logic [2:0] APR_REC_GPIO = 3'h0;
	// Primary word clock output codes
	localparam logic [1:0] APR_PW_PLAY = 2'h0;
	localparam logic [1:0] APR_PW_REC = 2'h1;
	localparam logic [1:0] APR_PW_SEC = 2'h2;
	// Secondary word clock output codes
	localparam logic [1:0] APR_SW_PRIM = 2'h0;
	localparam logic [1:0] APR_SW_PLAY = 2'h1;
	localparam logic [1:0] APR_SW_REC = 2'h2;
endpackage

// [apr_routing.sv]
// Audio port routing: secondary pin sourcing, serial block feeds, pin outputs, flags.
// Assumes pins arrive asynchronously on clk_sys; internal clocks and flags are on clk_sys.
//
// Contract
// - secondary bit clock from gpio or dout pin
// - secondary word clock from gpio or dout pin
// - secondary data input from gpio or disconnected
// - record word clock source gpio, else reserved
// - bit selects primary/secondary bit clock inward
// - bit selects primary/secondary word clock inward
// - record word clock: playback one or routed
// - bit selects primary/secondary data input inward
// - primary bit clock pin: generated or secondary
// - secondary bit clock pin: primary or generated
// - primary word clock pin output source field
// - secondary word clock pin output source field
// - primary data out: serial data or passthrough
// - secondary data out: passthrough or serial data
// - general-call acceptance bit, reset ignores
// - record gain match and power status bits
// - sticky saturation flag, cleared by reading
// - playback and headphone power status bits
// - speaker driver power status bit
// - playback gain match status bit
// - direction bits make clocks outputs
`timescale 1ns/100ps
module apr_routing
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [apr_pkg::APR_REG_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [apr_pkg::APR_REG_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [apr_pkg::APR_REG_W-1:0] reg_rdata,
	// Pin inputs, asynchronous
	input wire logic prim_bclk_in,
	input wire logic prim_wclk_in,
	input wire logic prim_din,
	input wire logic general_purpose_pin_one_in,
	input wire logic dout_pin_in,
	// Internal clocks and data, clk_sys domain
	input wire logic gen_bclk,
	input wire logic playback_sample_rate_clock,
	input wire logic record_sample_rate_clock,
	input wire logic sif_dout,
	input wire logic bclk_drive_out,
	input wire logic wclk_drive_out,
	// Status sources
	input wire logic rec_gain_match,
	input wire logic rec_powered,
	input wire logic agc_at_max,
	input wire logic play_powered,
	input wire logic headphone_driver_powered,
	input wire logic classd_powered,
	input wire logic play_gain_match,
	// Feeds to serial-interface and clock generator
	output logic sif_bclk,
	output logic clock_generator_bclk,
	output logic sif_wclk,
	output logic sif_rec_wclk,
	output logic sif_din,
	output logic general_call_accept,
	// Pin outputs with enables
	output logic prim_bclk_out,
	output logic prim_bclk_oe,
	output logic prim_wclk_out,
	output logic prim_wclk_oe,
	output logic prim_dout_out,
	output logic prim_dout_oe,
	output logic sec_bclk_out,
	output logic sec_bclk_oe,
	output logic sec_wclk_out,
	output logic sec_wclk_oe,
	output logic sec_dout_out,
	output logic sec_dout_oe
);
	import apr_pkg::*;

	// Pin indices in the synchroniser vector
	localparam int PIN_PBCLK = 0;
	localparam int PIN_PWCLK = 1;
	localparam int PIN_PDIN = 2;
	localparam int PIN_GPIO = 3;
	localparam int PIN_DOUT = 4;
	localparam int PIN_N = 5;

	// Control registers
	logic [7:0] src_sel; // Secondary pin source select
	logic [7:0] in_sel; // Serial port input select
	logic [7:0] out_sel; // Serial port output select
	logic [7:0] bus_cond; // Control bus condition
	logic [4:0] rec_rsvd; // Writable reserved record bits
	logic agc_sticky; // Sticky saturation flag
	logic agc_prev; // Saturation level, last cycle
	// Synchroniser stages and filtered pins
	logic [PIN_N-1:0] sync1;
	logic [PIN_N-1:0] sync2;
	logic [PIN_N-1:0] sync3;
	logic [PIN_N-1:0] pin_f;
	// Decoded secondary sources
	logic bclk_from_gpio, bclk_from_dout, wclk_from_gpio, wclk_from_dout; // Source code hits
	logic sec_bclk_ok;
	logic sec_wclk_ok;
	logic sec_din_ok;
	logic rec_wclk_ok;
	logic sec_bclk;
	logic sec_wclk;
	logic sec_din;
	logic rec_wclk;
	logic dout_is_input;
	logic agc_event;
	logic rd_clear;
	// Next values of registered outputs
	logic next_sif_bclk;
	logic next_sif_wclk;
	logic next_sif_rec_wclk;
	logic next_sif_din;
	logic next_prim_bclk_out;
	logic next_prim_bclk_oe;
	logic next_prim_wclk_out;
	logic next_prim_wclk_oe;
	logic next_prim_dout_out;
	logic next_prim_dout_oe;
	logic next_sec_bclk_out;
	logic next_sec_bclk_oe;
	logic next_sec_wclk_out;
	logic next_sec_wclk_oe;
	logic next_sec_dout_out;
	logic next_sec_dout_oe;
	logic [7:0] next_rdata;

	// Register port width is fixed by the map
	if (APR_REG_W != 8)
	begin : g_width_check
		$error("apr_routing needs an 8-bit register port");
	end

	// Three-stage pin synchroniser, change taken when stages two and three agree
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			pin_f <= '0;
		end
		else
		begin
			sync1 <= {dout_pin_in, general_purpose_pin_one_in, prim_din, prim_wclk_in,
				prim_bclk_in};
			sync2 <= sync1;
			sync3 <= sync2;
			// Per bit: hold until the later stages agree
			for (int i = 0; i < PIN_N; i++)
			begin
				if (sync2[i] == sync3[i])
				begin
					pin_f[i] <= sync3[i];
				end
			end
		end
	end

	// Routing control register writes
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			src_sel <= APR_RST_REG;
			in_sel <= APR_RST_REG;
			out_sel <= APR_RST_REG;
			bus_cond <= APR_RST_REG;
			rec_rsvd <= APR_RST_REG[4:0];
		end
		else if (reg_wr)
		begin
			// Reserved bits are stored as written; host keeps them zero
			case (reg_addr)
				APR_OFS_SRC_SEL: src_sel <= reg_wdata;
				APR_OFS_IN_SEL: in_sel <= reg_wdata;
				APR_OFS_OUT_SEL: out_sel <= reg_wdata;
				APR_OFS_BUS_COND: bus_cond <= reg_wdata;
				APR_OFS_REC_FLAGS: rec_rsvd <= reg_wdata[4:0] & APR_REC_RW_MASK[4:0];
				default: ; // Read-only or unmapped: write ignored
			endcase
		end
	end

	// Sticky saturation flag; a new event beats a clearing read
	assign agc_event = agc_at_max && !agc_prev;
	assign rd_clear = reg_rd && (reg_addr == APR_OFS_REC_FLAGS);
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			agc_prev <= 1'b0;
			agc_sticky <= 1'b0;
		end
		else
		begin
			agc_prev <= agc_at_max;
			if (agc_event)
			begin
				agc_sticky <= 1'b1;
			end
			else if (rd_clear)
			begin
				agc_sticky <= 1'b0;
			end
		end
	end

	// Secondary clock source decode; not-obtained and reserved codes leave the signal low
	assign bclk_from_gpio = (src_sel[APR_POS_SEC_BCLK_SRC +: 3] == APR_SRC_GPIO);
	assign bclk_from_dout = (src_sel[APR_POS_SEC_BCLK_SRC +: 3] == APR_SRC_DOUT);
	assign wclk_from_gpio = (src_sel[APR_POS_SEC_WCLK_SRC +: 3] == APR_SRC_GPIO);
	assign wclk_from_dout = (src_sel[APR_POS_SEC_WCLK_SRC +: 3] == APR_SRC_DOUT);
	assign sec_bclk_ok = bclk_from_gpio || bclk_from_dout;
	assign sec_wclk_ok = wclk_from_gpio || wclk_from_dout;
	assign sec_bclk = (bclk_from_gpio && pin_f[PIN_GPIO]) || (bclk_from_dout && pin_f[PIN_DOUT]);
	assign sec_wclk = (wclk_from_gpio && pin_f[PIN_GPIO]) || (wclk_from_dout && pin_f[PIN_DOUT]);

	// Secondary data input and record word clock
	assign sec_din_ok = (src_sel[APR_POS_SEC_DIN_SRC +: 2] == APR_DIN_GPIO);
	assign sec_din = sec_din_ok && pin_f[PIN_GPIO];
	assign rec_wclk_ok = (in_sel[APR_POS_REC_WCLK_SRC +: 3] == APR_REC_GPIO);
	assign rec_wclk = rec_wclk_ok && pin_f[PIN_GPIO];
	// Data-out pin turns input while it sources a secondary clock
	assign dout_is_input = bclk_from_dout || wclk_from_dout;

	// Feeds into the serial-interface block
	always_comb
	begin
		next_sif_bclk = in_sel[APR_POS_SIF_BCLK_SEL] ? sec_bclk : pin_f[PIN_PBCLK];
		next_sif_wclk = in_sel[APR_POS_SIF_WCLK_SEL] ? sec_wclk : pin_f[PIN_PWCLK];
		next_sif_rec_wclk = in_sel[APR_POS_REC_WCLK_SEL] ? rec_wclk : next_sif_wclk;
		next_sif_din = in_sel[APR_POS_SIF_DIN_SEL] ? sec_din : pin_f[PIN_PDIN];
	end

	// Bit clock and data pin outputs
	always_comb
	begin
		// Primary bit clock pin
		next_prim_bclk_out = out_sel[APR_POS_PBCLK_OUT] ? sec_bclk : gen_bclk;
		next_prim_bclk_oe = bclk_drive_out && (!out_sel[APR_POS_PBCLK_OUT] || sec_bclk_ok);
		// Secondary bit clock pin
		next_sec_bclk_out = out_sel[APR_POS_SBCLK_OUT] ? gen_bclk : pin_f[PIN_PBCLK];
		next_sec_bclk_oe = bclk_drive_out && sec_bclk_ok;
		// Primary data out
		next_prim_dout_out = out_sel[APR_POS_PDOUT_SEL] ? sec_din : sif_dout;
		next_prim_dout_oe = !dout_is_input && (!out_sel[APR_POS_PDOUT_SEL] || sec_din_ok);
		// Secondary data out, driven while the secondary port is in use
		next_sec_dout_out = out_sel[APR_POS_SDOUT_SEL] ? sif_dout : pin_f[PIN_PDIN];
		next_sec_dout_oe = sec_bclk_ok || sec_wclk_ok;
	end

	// Word clock pin outputs; reserved codes release the pin
	always_comb
	begin
		next_prim_wclk_out = 1'b0;
		next_prim_wclk_oe = 1'b0;
		next_sec_wclk_out = 1'b0;
		// Primary word clock pin
		case (out_sel[APR_POS_PWCLK_OUT +: 2])
			APR_PW_PLAY:
			begin
				next_prim_wclk_out = playback_sample_rate_clock;
				next_prim_wclk_oe = wclk_drive_out;
			end
			APR_PW_REC:
			begin
				next_prim_wclk_out = record_sample_rate_clock;
				next_prim_wclk_oe = wclk_drive_out;
			end
			APR_PW_SEC:
			begin
				next_prim_wclk_out = sec_wclk;
				next_prim_wclk_oe = wclk_drive_out && sec_wclk_ok;
			end
			default: ; // Reserved: pin released
		endcase
		// Secondary word clock pin
		case (out_sel[APR_POS_SWCLK_OUT +: 2])
			APR_SW_PRIM: next_sec_wclk_out = pin_f[PIN_PWCLK];
			APR_SW_PLAY: next_sec_wclk_out = playback_sample_rate_clock;
			APR_SW_REC: next_sec_wclk_out = record_sample_rate_clock;
			default: ; // Reserved: pin released
		endcase
		// Both field bits set is the reserved code: pin released
		next_sec_wclk_oe = wclk_drive_out && sec_wclk_ok && !(&out_sel[APR_POS_SWCLK_OUT +: 2]);
	end

	// Read data mux, status bits shown live
	always_comb
	begin
		next_rdata = 8'h00;
		case (reg_addr)
			APR_OFS_SRC_SEL: next_rdata = src_sel;
			APR_OFS_IN_SEL: next_rdata = in_sel;
			APR_OFS_OUT_SEL: next_rdata = out_sel;
			APR_OFS_BUS_COND: next_rdata = bus_cond;
			APR_OFS_REC_FLAGS:
			begin
				next_rdata[4:0] = rec_rsvd;
				next_rdata[APR_POS_ADC_GAIN_OK] = rec_gain_match;
				next_rdata[APR_POS_ADC_PWR] = rec_powered;
				next_rdata[APR_POS_AGC_SAT] = agc_sticky || agc_event;
			end
			APR_OFS_PLAY_PWR:
			begin
				next_rdata[APR_POS_DAC_PWR] = play_powered;
				next_rdata[APR_POS_HP_PWR] = headphone_driver_powered;
				next_rdata[APR_POS_CLASSD_PWR] = classd_powered;
			end
			APR_OFS_PLAY_GAIN: next_rdata[APR_POS_DAC_GAIN_OK] = play_gain_match;
			default: next_rdata = 8'h00; // Reserved slot and unmapped read zero
		endcase
	end

	// Registered outputs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			reg_rdata <= 8'h00;
			{sif_bclk, clock_generator_bclk, sif_wclk, sif_rec_wclk, sif_din} <= '0;
			general_call_accept <= 1'b0;
			{prim_bclk_out, prim_bclk_oe, prim_wclk_out, prim_wclk_oe} <= '0;
			{prim_dout_out, prim_dout_oe, sec_dout_out, sec_dout_oe} <= '0;
			{sec_bclk_out, sec_bclk_oe, sec_wclk_out, sec_wclk_oe} <= '0;
		end
		else
		begin
			if (reg_rd)
			begin
				reg_rdata <= next_rdata;
			end
			sif_bclk <= next_sif_bclk;
			clock_generator_bclk <= next_sif_bclk;
			sif_wclk <= next_sif_wclk;
			sif_rec_wclk <= next_sif_rec_wclk;
			sif_din <= next_sif_din;
			general_call_accept <= bus_cond[APR_POS_GCALL];
			prim_bclk_out <= next_prim_bclk_out;
			prim_bclk_oe <= next_prim_bclk_oe;
			prim_wclk_out <= next_prim_wclk_out;
			prim_wclk_oe <= next_prim_wclk_oe;
			prim_dout_out <= next_prim_dout_out;
			prim_dout_oe <= next_prim_dout_oe;
			sec_bclk_out <= next_sec_bclk_out;
			sec_bclk_oe <= next_sec_bclk_oe;
			sec_wclk_out <= next_sec_wclk_out;
			sec_wclk_oe <= next_sec_wclk_oe;
			sec_dout_out <= next_sec_dout_out;
			sec_dout_oe <= next_sec_dout_oe;
		end
	end

	// Checks on routing and flags
	a_sec_bclk_gpio: assert property (@(posedge clk_sys) disable iff (rst)
		(src_sel[7:5] == 3'h0 && in_sel[3]) |=> sif_bclk == $past(pin_f[PIN_GPIO]))
		else $error("secondary bit clock not taken from gpio");
	a_sec_wclk_dout: assert property (@(posedge clk_sys) disable iff (rst)
		(src_sel[4:2] == 3'h3 && in_sel[2]) |=> sif_wclk == $past(pin_f[PIN_DOUT]))
		else $error("secondary word clock not taken from dout pin");
	a_din_prim_sel: assert property (@(posedge clk_sys) disable iff (rst)
		!in_sel[0] |=> sif_din == $past(pin_f[PIN_PDIN]))
		else $error("primary data input not fed inward");
	a_rec_wclk_same: assert property (@(posedge clk_sys) disable iff (rst)
		!in_sel[1] |=> sif_rec_wclk == sif_wclk)
		else $error("record word clock differs from playback word clock");
	a_pbclk_gen: assert property (@(posedge clk_sys) disable iff (rst)
		(!out_sel[7] && bclk_drive_out) |=> prim_bclk_oe && prim_bclk_out == $past(gen_bclk))
		else $error("primary bit clock pin not carrying generated clock");
	a_bclk_input_dir: assert property (@(posedge clk_sys) disable iff (rst)
		!bclk_drive_out |=> !prim_bclk_oe && !sec_bclk_oe)
		else $error("bit clock pin driven while set as input");
	a_pwclk_rsvd: assert property (@(posedge clk_sys) disable iff (rst)
		(out_sel[5:4] == 2'h3) |=> !prim_wclk_oe)
		else $error("primary word clock pin driven on reserved code");
	a_gcall_follow: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(bus_cond[5]) |=> general_call_accept)
		else $error("general-call acceptance not following its bit");
	a_agc_set: assert property (@(posedge clk_sys) disable iff (rst)
		(agc_at_max && !agc_prev) |=> agc_sticky)
		else $error("sticky saturation flag missed an event");
	a_agc_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(rd_clear && !agc_event) ##1 !agc_event |=> !agc_sticky)
		else $error("sticky saturation flag not cleared by read");
	a_play_pwr_rd: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == 8'h25) |=> reg_rdata[7] == $past(play_powered))
		else $error("playback power status misreported");
endmodule // apr_routing

// [apr_partner.sv]
// Far-side audio device model: drives the primary pins and the gpio and data-out pads.
// Assumes the bench sets static pin levels; the bit clock runs only while run is high.
`timescale 1ns/100ps
module apr_partner
(
	// Control from the bench
	input wire logic run,
	input wire logic [4:0] lvl,
	// Pins into the block
	output logic prim_bclk_in,
	output logic prim_wclk_in,
	output logic prim_din,
	output logic gpio_in,
	output logic dout_in
);
	// Link clock, 320 ns period, phase unrelated to the system clock
	logic lclk;
	initial
	begin
		lclk = 1'b0;
		#7;
		forever #160 lclk = ~lclk;
	end
	// Bit clock stands at its static level outside frames
	assign prim_bclk_in = run ? lclk : lvl[4];
	// Word clock, data and pad levels as the bench asks
	assign {prim_wclk_in, prim_din, gpio_in, dout_in} = lvl[3:0];
endmodule // apr_partner

// [apr_routing_tb.sv]
// Self-checking bench for the audio port routing and flag block.
// Assumes apr_pkg and apr_partner are compiled before it.
`timescale 1ns/100ps
module apr_routing_tb;
	import apr_pkg::*;
	// Clock, reset and register port
	logic clk_sys;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	wire logic [7:0] reg_rdata;
	// Partner control and pin wires
	logic run = 1'b0;
	logic [4:0] lvl = 5'h00;
	wire logic prim_bclk_in, prim_wclk_in, prim_din, gpio_in, dout_in;
	// Generated bclk, playback rate, record rate, serial data out
	logic [3:0] intl = 4'h0;
	// Status levels and clock direction bits
	logic [6:0] st = 7'h00;
	logic [1:0] drv = 2'h0;
	// Observed feeds, pin values, pin enables
	wire logic [4:0] feed;
	wire logic [5:0] pout, poe;
	wire logic gca;
	// Bookkeeping
	int fails = 0;
	int checks = 0;
	int cyc = 0;

	// Far side of the pins
	apr_partner far_u (.run(run), .lvl(lvl), .prim_bclk_in(prim_bclk_in),
		.prim_wclk_in(prim_wclk_in), .prim_din(prim_din), .gpio_in(gpio_in), .dout_in(dout_in));

	// Block under test
	apr_routing dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.prim_bclk_in(prim_bclk_in), .prim_wclk_in(prim_wclk_in), .prim_din(prim_din),
		.general_purpose_pin_one_in(gpio_in), .dout_pin_in(dout_in),
		.gen_bclk(intl[3]), .playback_sample_rate_clock(intl[2]),
		.record_sample_rate_clock(intl[1]), .sif_dout(intl[0]),
		.bclk_drive_out(drv[1]), .wclk_drive_out(drv[0]),
		.rec_gain_match(st[6]), .rec_powered(st[5]), .agc_at_max(st[4]),
		.play_powered(st[3]), .headphone_driver_powered(st[2]), .classd_powered(st[1]),
		.play_gain_match(st[0]), .sif_bclk(feed[4]), .clock_generator_bclk(feed[3]),
		.sif_wclk(feed[2]), .sif_rec_wclk(feed[1]), .sif_din(feed[0]),
		.general_call_accept(gca), .prim_bclk_out(pout[5]), .prim_bclk_oe(poe[5]),
		.prim_wclk_out(pout[4]), .prim_wclk_oe(poe[4]), .prim_dout_out(pout[3]),
		.prim_dout_oe(poe[3]), .sec_bclk_out(pout[2]), .sec_bclk_oe(poe[2]),
		.sec_wclk_out(pout[1]), .sec_wclk_oe(poe[1]), .sec_dout_out(pout[0]),
		.sec_dout_oe(poe[0]));

	// System clock, 40 ns
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic stop_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			stop_test();
		end
	end

	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One write, strobe held one cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// One read, data settled one edge after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		#1 d = reg_rdata;
	endtask

	// Set status levels, then read the three flag registers
	task automatic stat(input logic [6:0] v, input logic [7:0] e4, e5, e6);
		logic [7:0] r;
		@(posedge clk_sys);
		st <= v;
		repeat (2) @(posedge clk_sys);
		rd(APR_OFS_REC_FLAGS, r);
		chk(r, e4);
		rd(APR_OFS_PLAY_PWR, r);
		chk(r, e5);
		rd(APR_OFS_PLAY_GAIN, r);
		chk(r, e6);
	endtask

	// Program routing, set levels, wait out the synchronisers, compare
	task automatic route(input logic [7:0] s, i, o, input logic [4:0] p, input logic [3:0] n,
		input logic [1:0] d, input logic [4:0] ef, input logic [5:0] ep, eo, input bit f);
		logic [7:0] r;
		wr(APR_OFS_SRC_SEL, s);
		wr(APR_OFS_IN_SEL, i);
		wr(APR_OFS_OUT_SEL, o);
		rd(APR_OFS_SRC_SEL, r);
		chk(r, s);
		rd(APR_OFS_OUT_SEL, r);
		chk(r, o);
		@(posedge clk_sys);
		lvl <= p;
		intl <= n;
		drv <= d;
		repeat (8) @(posedge clk_sys);
		#1;
		chk({3'h0, feed}, {3'h0, ef});
		// Pin values only matter where the pin is driven
		if (f)
		begin
			chk({2'h0, pout & eo}, {2'h0, ep & eo});
			chk({2'h0, poe}, {2'h0, eo});
		end
	endtask

	// Main sequence
	initial
	begin
		logic [7:0] r;
		int n;
		logic prev;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		// Reset values of all offsets and an unmapped one
		for (int a = 8'h1f; a <= 8'h26; a++)
		begin
			rd(8'(a), r);
			chk(r, APR_RST_REG);
		end
		wr(8'h40, 8'h5a);
		rd(8'h40, r);
		chk(r, 8'h00);
		chk({7'h00, gca}, 8'h00);
		$display("test reset done");
		// General-call acceptance set and cleared
		wr(APR_OFS_BUS_COND, 8'h20);
		rd(APR_OFS_BUS_COND, r);
		chk(r, 8'h20);
		chk({7'h00, gca}, 8'h01);
		wr(APR_OFS_BUS_COND, 8'h00);
		@(posedge clk_sys);
		#1 chk({7'h00, gca}, 8'h00);
		$display("test general call done");
		// Status levels and the sticky saturation flag
		stat(7'h6f, 8'hc0, 8'hb0, 8'h10);
		stat(7'h10, 8'h20, 8'h00, 8'h00);
		rd(APR_OFS_REC_FLAGS, r);
		chk(r, 8'h00);
		stat(7'h00, 8'h00, 8'h00, 8'h00);
		stat(7'h10, 8'h20, 8'h00, 8'h00);
		$display("test flags done");
		// Inward selection and secondary sourcing
		route(8'h00, 8'h0f, 8'h00, 5'h02, 4'h0, 2'h3, 5'h1f, 6'h00, 6'h00, 0);
		route(8'h00, 8'h00, 8'h00, 5'h0c, 4'h0, 2'h3, 5'h07, 6'h00, 6'h00, 0);
		route(8'h6d, 8'h0f, 8'h00, 5'h01, 4'h0, 2'h3, 5'h1c, 6'h00, 6'h00, 0);
		route(8'h24, 8'h0f, 8'h00, 5'h03, 4'h0, 2'h3, 5'h03, 6'h00, 6'h00, 0);
		route(8'h90, 8'h0f, 8'h00, 5'h03, 4'h0, 2'h3, 5'h03, 6'h00, 6'h00, 0);
		route(8'h02, 8'h0f, 8'h00, 5'h02, 4'h0, 2'h3, 5'h1e, 6'h00, 6'h00, 0);
		route(8'h00, 8'h2f, 8'h00, 5'h02, 4'h0, 2'h3, 5'h1d, 6'h00, 6'h00, 0);
		$display("test inward routing done");
		// Pin output selection and enables
		route(8'h00, 8'h00, 8'h00, 5'h1c, 4'hc, 2'h3, 5'h1f, 6'h37, 6'h3f, 1);
		route(8'h00, 8'h00, 8'h00, 5'h1c, 4'hc, 2'h0, 5'h1f, 6'h37, 6'h09, 1);
		route(8'h00, 8'h00, 8'hdb, 5'h00, 4'hb, 2'h3, 5'h00, 6'h17, 6'h3f, 1);
		route(8'h00, 8'h00, 8'h24, 5'h0a, 4'h1, 2'h3, 5'h06, 6'h18, 6'h3f, 1);
		route(8'h24, 8'h00, 8'h00, 5'h1c, 4'hc, 2'h3, 5'h1f, 6'h30, 6'h38, 1);
		route(8'h6d, 8'h00, 8'h3e, 5'h01, 4'h8, 2'h3, 5'h00, 6'h20, 6'h25, 1);
		$display("test pin routing done");
		// Running link clock reaches the serial block: 12 periods in 96 cycles
		@(posedge clk_sys);
		run <= 1'b1;
		n = 0;
		prev = 1'b1;
		repeat (96)
		begin
			@(posedge clk_sys);
			#1;
			if (feed[4] === 1'b1 && prev === 1'b0)
				n++;
			prev = feed[4];
		end
		run <= 1'b0;
		chk({7'h00, n >= 11 && n <= 13}, 8'h01);
		$display("test link clock done");
		stop_test();
	end
endmodule // apr_routing_tb
